/* File: crp_map.svh */
// Address map, vector slots and sizes of the core register block.
// Assumes an 8-bit data space and a 12-bit program space.
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH
`define CRP_ADDR_XPTR     8'h80
`define CRP_ADDR_YPTR     8'h81
`define CRP_ADDR_VSD      8'h82
`define CRP_ADDR_WSD      8'h83
`define CRP_ADDR_ACC      8'hFF
`define CRP_IDX_NONE      3'h7
`define CRP_NREG          5
`define CRP_VEC_RESET     12'hFFE
`define CRP_VEC_NMI       12'hFFC
`define CRP_VEC_IRQ_BASE  12'hFF0
`define CRP_USER_LO_SMALL 12'h880
`define CRP_USER_LO_LARGE 12'h080
`define CRP_USER_HI       12'hF9F
`define CRP_STACK_DEPTH   6
`define CRP_PC_W          12
`define CRP_NCTX          3
`endif

/* File: crp_pkg.sv */
// Types shared by the core register block and its users.
// Assumes crp_map.svh is on the include path.
`include "crp_map.svh"
package crp_pkg;
  // Flag context in use
  typedef enum logic [1:0] {CRP_CTX_NORMAL, CRP_CTX_IRQ, CRP_CTX_NMI} crp_ctx_t;
  // Program counter load source
  typedef enum logic [3:0] {
    CRP_PC_HOLD, CRP_PC_INC, CRP_PC_JUMP, CRP_PC_CALL, CRP_PC_BRANCH,
    CRP_PC_RET, CRP_PC_RETURN_FROM_INTERRUPT, CRP_PC_IRQ, CRP_PC_NMI
  } crp_pcop_t;
  // Data space addressing mode
  typedef enum logic [1:0] {CRP_DA_DIRECT, CRP_DA_SHORT, CRP_DA_BIT} crp_dmode_t;
  // Data space access from the sequencer
  typedef struct packed {
    logic       req;
    logic       wr;
    crp_dmode_t mode;
    logic [7:0] addr;
    logic [1:0] sd_sel;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [7:0] wdata;
  } crp_dacc_t;
  // One carry/zero pair
  typedef struct packed {
    logic carry;
    logic zero;
  } crp_flag_t;
  // Flag update from the arithmetic unit
  typedef struct packed {
    logic       we;
    logic       carry;
    logic [7:0] result;
  } crp_alu_t;
  // Program counter request
  typedef struct packed {
    crp_pcop_t                op;
    logic [`CRP_PC_W-1:0]     target;
    logic [7:0]               offset;
    logic [1:0]               irq_line;
  } crp_pcreq_t;
endpackage : crp_pkg

/* File: crp_stack.sv */
// Hardware return stack, shift-register style, no pointer into memory.
// Assumes push and pop are never asserted together.
`include "crp_map.svh"
module crp_stack #(
  parameter int DEPTH = `CRP_STACK_DEPTH,
  parameter int W     = `CRP_PC_W
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         push_i,
  input  wire logic         pop_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] top_o,
  output logic              empty_o
);
  logic [W-1:0] stk_reg [DEPTH];   // Entry 0 is the top
  logic [3:0]   cnt_reg;           // Live entries, saturates at DEPTH

  // Entry 0 takes the pushed value or the one below on a pop
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stk_reg[0] <= '0;
    end else if (push_i) begin
      stk_reg[0] <= din_i;
    end else if (pop_i && !empty_o) begin
      stk_reg[0] <= stk_reg[1];
    end
  end

  // Deeper entries shift; the oldest falls off the bottom on overflow
  for (genvar i = 1; i < DEPTH; i++) begin : g_lvl
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        stk_reg[i] <= '0;
      end else if (push_i) begin
        stk_reg[i] <= stk_reg[i-1];
      end else if (pop_i && !empty_o) begin
        stk_reg[i] <= (i == DEPTH-1) ? stk_reg[i] : stk_reg[(i+1) % DEPTH];
      end
    end
  end

  // Depth count stays at its ends instead of wrapping
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
    end else if (push_i && cnt_reg != 4'(DEPTH)) begin
      cnt_reg <= cnt_reg + 4'h1;
    end else if (pop_i && cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  assign top_o   = stk_reg[0];
  assign empty_o = (cnt_reg == 4'h0);
endmodule : crp_stack

/* File: crp_core.sv */
// Programmer-visible core state: mapped registers, program counter,
// banked flags and vector loading.
// Assumes the sequencer holds requests only while busy_o is low and that
// program memory returns pm_data_i one clock after pm_rd_o.
`include "crp_map.svh"

// How it works
// - Accumulator readable and writable at FFh
// - Index pointers at 80h and 81h
// - Short-direct registers at 82h and 83h
// - Short-direct selector reaches all four registers
// - Twelve-bit program counter covers 4096 bytes
// - Program counter increments on an increment request or on a return with the stack empty
// - Branch adds signed offset to counter
// - Counter loads jump, call, vector or stack
// - Vectors at FFEh, FFCh and FF0h-FF7h
// - Flag counter outside user program space
// - Three carry/zero pairs kept separately
// - Interrupt switches pair; return restores previous
// - Pairs keep values across context switches
// - Only the active pair is seen or updated
// - Six-entry return stack pushes and pops counter
// - Overflow drops oldest; empty return just continues
// - Reset starts in non-maskable context
// - Zero from result, carry from arithmetic unit
module crp_core #(
  parameter bit LARGE_MEM = 1'b1      // Selects the user space lower bound
) (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire crp_pkg::crp_dacc_t   dacc_i,       // Data space access
  input  wire crp_pkg::crp_alu_t    alu_i,        // Flag update
  input  wire crp_pkg::crp_pcreq_t  pcreq_i,      // Counter request
  input  wire logic [7:0]           pm_data_i,    // Program memory byte
  output logic [7:0]                rdata_o,      // Read data
  output logic                      hit_o,        // Access hit this block
  output logic [`CRP_PC_W-1:0]      pc_o,         // Program counter
  output logic                      pc_resv_o,    // Counter in reserved space
  output logic                      pm_rd_o,      // Program memory read
  output logic [`CRP_PC_W-1:0]      pm_addr_o,    // Program memory address
  output logic                      busy_o,       // Vector fetch in progress
  output crp_pkg::crp_flag_t        flag_o,       // Active flag pair
  output crp_pkg::crp_ctx_t         ctx_o,        // Active context
  output logic                      stk_empty_o   // Return stack empty
);
  import crp_pkg::*;

  typedef enum logic [1:0] {CRP_ST_RUN, CRP_ST_VLO, CRP_ST_VHI, CRP_ST_VEND} crp_state_t;

  logic [7:0]          dreg_reg [`CRP_NREG];    // 80h..83h then FFh
  crp_flag_t           flag_reg [`CRP_NCTX];    // One pair per context
  crp_state_t          state_reg;               // Vector fetch sequencer
  crp_state_t          state_next;
  logic [`CRP_PC_W-1:0] pc_reg;                 // Counter
  logic [`CRP_PC_W-1:0] pc_next;
  logic [7:0]          vlo_reg;                 // Captured vector low byte
  crp_ctx_t            ctx_reg;                 // Active context
  crp_ctx_t            ctx_next;
  crp_ctx_t            irq_prev_reg;            // Context to resume after irq
  crp_ctx_t            nmi_prev_reg;            // Context to resume after nmi
  logic                run;                     // Requests accepted
  logic                push;                    // Stack push
  logic                pop;                     // Stack pop
  logic [`CRP_PC_W-1:0] stk_top;                // Top return address
  logic                stk_empty;               // Stack has no entries
  logic [7:0]          eff_addr;                // Effective data address
  logic [2:0]          idx;                     // Register index or none
  logic [7:0]          wval;                    // Value to write

  // Short-direct selector to data address; X and Y are selectable too
  function automatic logic [7:0] sd_addr(input logic [1:0] sel);
    case (sel)
      2'h0:    sd_addr = `CRP_ADDR_XPTR;
      2'h1:    sd_addr = `CRP_ADDR_YPTR;
      2'h2:    sd_addr = `CRP_ADDR_VSD;
      default: sd_addr = `CRP_ADDR_WSD;
    endcase
  endfunction : sd_addr

  // Data address to register index
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    case (a)
      `CRP_ADDR_XPTR: reg_idx = 3'h0;
      `CRP_ADDR_YPTR: reg_idx = 3'h1;
      `CRP_ADDR_VSD:  reg_idx = 3'h2;
      `CRP_ADDR_WSD:  reg_idx = 3'h3;
      `CRP_ADDR_ACC:  reg_idx = 3'h4;
      default:        reg_idx = `CRP_IDX_NONE;
    endcase
  endfunction : reg_idx

  // Reserved program space test; vector slots are fetched, not run
  function automatic logic pc_reserved(input logic [`CRP_PC_W-1:0] a);
    logic [`CRP_PC_W-1:0] lo;
    lo = LARGE_MEM ? `CRP_USER_LO_LARGE : `CRP_USER_LO_SMALL;
    pc_reserved = (a < lo) || (a > `CRP_USER_HI);
  endfunction : pc_reserved

  // Branch sum formed as a twelve-bit signed add
  function automatic logic [`CRP_PC_W-1:0] alu_add(input logic [`CRP_PC_W-1:0] a,
                                                  input logic [7:0] off);
    alu_add = a + {{(`CRP_PC_W-8){off[7]}}, off};
  endfunction : alu_add

  assign run = (state_reg == CRP_ST_RUN);

  // Data access decode: short mode picks from the selector
  always_comb begin
    eff_addr = (dacc_i.mode == CRP_DA_SHORT) ? sd_addr(dacc_i.sd_sel) : dacc_i.addr;
    idx      = reg_idx(eff_addr);
    wval     = dacc_i.wdata;
    if (dacc_i.mode == CRP_DA_BIT && idx != `CRP_IDX_NONE) begin
      wval = dreg_reg[idx];
      wval[dacc_i.bit_idx] = dacc_i.bit_val;
    end
  end

  // Each mapped register takes writes at its own address
  for (genvar r = 0; r < `CRP_NREG; r++) begin : g_dreg
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        dreg_reg[r] <= 8'h00;
      end else if (dacc_i.req && dacc_i.wr && idx == 3'(r)) begin
        dreg_reg[r] <= wval;
      end
    end
  end

  // Read port answers one clock after the request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      hit_o   <= 1'b0;
    end else begin
      hit_o   <= dacc_i.req && (idx != `CRP_IDX_NONE);
      rdata_o <= (dacc_i.req && !dacc_i.wr && idx != `CRP_IDX_NONE) ? dreg_reg[idx] : 8'h00;
    end
  end

  // Vector fetch sequencer; reset starts a fetch straight away
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CRP_ST_RUN:  if (pcreq_i.op == CRP_PC_IRQ || pcreq_i.op == CRP_PC_NMI) begin
                     state_next = CRP_ST_VLO;
                   end
      CRP_ST_VLO:  state_next = CRP_ST_VHI;
      CRP_ST_VHI:  state_next = CRP_ST_VEND;
      CRP_ST_VEND: state_next = CRP_ST_RUN;
      default:     state_next = CRP_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= CRP_ST_VLO;
    end else begin
      state_reg <= state_next;
    end
  end

  // Program memory port walks the two vector bytes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pm_rd_o   <= 1'b1;
      pm_addr_o <= `CRP_VEC_RESET;
    end else if (run && pcreq_i.op == CRP_PC_NMI) begin
      pm_rd_o   <= 1'b1;
      pm_addr_o <= `CRP_VEC_NMI;
    end else if (run && pcreq_i.op == CRP_PC_IRQ) begin
      pm_rd_o   <= 1'b1;
      pm_addr_o <= `CRP_VEC_IRQ_BASE + {9'h000, pcreq_i.irq_line, 1'b0};
    end else if (state_reg == CRP_ST_VLO) begin
      pm_addr_o <= pm_addr_o + 12'h001;
    end else begin
      pm_rd_o   <= 1'b0;
    end
  end

  // Low byte of the vector is held until the high nibble arrives
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vlo_reg <= 8'h00;
    end else if (state_reg == CRP_ST_VHI) begin
      vlo_reg <= pm_data_i;
    end
  end

  // Stack moves only for accepted calls, interrupts and returns
  assign push = run && (pcreq_i.op == CRP_PC_CALL || pcreq_i.op == CRP_PC_IRQ ||
                        pcreq_i.op == CRP_PC_NMI);
  assign pop  = run && (pcreq_i.op == CRP_PC_RET || pcreq_i.op == CRP_PC_RETURN_FROM_INTERRUPT);

  crp_stack #(
    .DEPTH (`CRP_STACK_DEPTH),
    .W     (`CRP_PC_W)
  ) u_stack (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .push_i  (push),
    .pop_i   (pop),
    .din_i   (pc_reg),
    .top_o   (stk_top),
    .empty_o (stk_empty)
  );

  // Counter source selection
  always_comb begin
    pc_next = pc_reg;
    if (state_reg == CRP_ST_VEND) begin
      pc_next = {pm_data_i[3:0], vlo_reg};
    end else if (run) begin
      case (pcreq_i.op)
        CRP_PC_INC:    pc_next = pc_reg + 12'h001;
        CRP_PC_JUMP,
        CRP_PC_CALL:   pc_next = pcreq_i.target;
        CRP_PC_BRANCH: pc_next = alu_add(pc_reg, pcreq_i.offset);
        CRP_PC_RET,
        CRP_PC_RETURN_FROM_INTERRUPT:   pc_next = stk_empty ? pc_reg + 12'h001 : stk_top;
        default:       pc_next = pc_reg;
      endcase
    end
  end

  // Counter itself; twelve bits wrap at 4096
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_reg <= '0;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Context switching; a return from the bottom context stays there
  always_comb begin
    ctx_next = ctx_reg;
    if (run) begin
      case (pcreq_i.op)
        CRP_PC_IRQ:  ctx_next = CRP_CTX_IRQ;
        CRP_PC_NMI:  ctx_next = CRP_CTX_NMI;
        CRP_PC_RETURN_FROM_INTERRUPT: ctx_next = (ctx_reg == CRP_CTX_NMI) ? nmi_prev_reg :
                                (ctx_reg == CRP_CTX_IRQ) ? irq_prev_reg : ctx_reg;
        default:     ctx_next = ctx_reg;
      endcase
    end
  end

  // Each interrupt level remembers whom it interrupted
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctx_reg      <= CRP_CTX_NMI;
      nmi_prev_reg <= CRP_CTX_NORMAL;
      irq_prev_reg <= CRP_CTX_NORMAL;
    end else begin
      ctx_reg <= ctx_next;
      if (run && pcreq_i.op == CRP_PC_NMI) begin
        nmi_prev_reg <= ctx_reg;
      end
      if (run && pcreq_i.op == CRP_PC_IRQ) begin
        irq_prev_reg <= ctx_reg;
      end
    end
  end

  // Only the active pair is written; the others hold untouched
  for (genvar c = 0; c < `CRP_NCTX; c++) begin : g_flag
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        flag_reg[c] <= '0;
      end else if (alu_i.we && ctx_reg == crp_ctx_t'(c)) begin
        flag_reg[c].carry <= alu_i.carry;
        flag_reg[c].zero  <= (alu_i.result == 8'h00);
      end
    end
  end

  // Registered views; the flag view follows the context being entered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o      <= '0;
      ctx_o       <= CRP_CTX_NMI;
      busy_o      <= 1'b1;
      pc_o        <= '0;
      pc_resv_o   <= 1'b1;
      stk_empty_o <= 1'b1;
    end else begin
      ctx_o       <= ctx_next;
      busy_o      <= (state_next != CRP_ST_RUN);
      pc_o        <= pc_next;
      pc_resv_o   <= pc_reserved(pc_next);
      stk_empty_o <= stk_empty && !push;
      if (alu_i.we && ctx_next == ctx_reg) begin
        flag_o <= '{carry: alu_i.carry, zero: (alu_i.result == 8'h00)};
      end else begin
        flag_o <= flag_reg[ctx_next];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_vec_issue;
    state_reg == CRP_ST_VLO && pm_rd_o;
  endsequence
  sequence s_vec_second;
    pm_rd_o && pm_addr_o == $past(pm_addr_o) + 12'h001;
  endsequence

  AST_PC_INC: assert property (run && pcreq_i.op == CRP_PC_INC |=> pc_o == $past(pc_o) + 12'h001)
    else $error("counter did not advance by one");
  AST_BRANCH: assert property (run && pcreq_i.op == CRP_PC_BRANCH |=>
                               pc_o == $past(pc_o) + {{4{$past(pcreq_i.offset[7])}}, $past(pcreq_i.offset)})
    else $error("branch sum wrong");
  AST_JUMP: assert property (run && pcreq_i.op == CRP_PC_JUMP |=> pc_o == $past(pcreq_i.target))
    else $error("jump target not loaded");
  AST_VEC_WALK: assert property (s_vec_issue |=> s_vec_second ##1 !pm_rd_o ##1 !busy_o)
    else $error("vector fetch walk wrong");
  AST_VEC_LOAD: assert property (state_reg == CRP_ST_VEND |=>
                                 pc_o == {$past(pm_data_i[3:0]), $past(vlo_reg)})
    else $error("vector not assembled");
  AST_NMI_CTX: assert property (run && pcreq_i.op == CRP_PC_NMI |=> ctx_o == CRP_CTX_NMI ##3 !busy_o)
    else $error("nmi context not entered");
  AST_RET_POP: assert property (pop && !stk_empty |=> pc_o == $past(stk_top))
    else $error("return did not pop stack");
  AST_RET_EMPTY: assert property (pop && stk_empty |=> pc_o == $past(pc_o) + 12'h001 && stk_empty)
    else $error("empty return did not continue");
  AST_FLAG_KEEP: assert property (ctx_reg != CRP_CTX_NORMAL |=> $stable(flag_reg[CRP_CTX_NORMAL]))
    else $error("inactive flag pair changed");
  AST_ZERO: assert property (alu_i.we |=> flag_reg[$past(ctx_reg)].zero == ($past(alu_i.result) == 8'h00))
    else $error("zero flag wrong");
  AST_ACC_WR: assert property (dacc_i.req && dacc_i.wr && dacc_i.mode == CRP_DA_DIRECT &&
                               dacc_i.addr == `CRP_ADDR_ACC |=> dreg_reg[4] == $past(dacc_i.wdata))
    else $error("accumulator write lost");
  // Requests offered while a vector is fetched leave counter and context alone
  AST_BUSY_HOLD: assert property (!run && state_reg != CRP_ST_VEND |=>
                                  $stable(pc_o) && $stable(ctx_o))
    else $error("request taken during vector fetch");
  AST_IRQ_CTX: assert property (run && pcreq_i.op == CRP_PC_IRQ |=> ctx_o == CRP_CTX_IRQ && busy_o)
    else $error("irq context not entered");
  // With no update pending, the view shows exactly the active context's pair
  AST_FLAG_VIEW: assert property (!alu_i.we |=> flag_o == flag_reg[ctx_reg])
    else $error("flag view not the active pair");
endmodule : crp_core

/* File: crp_pmem_model.sv */
// Program memory stand-in that answers the core's vector reads.
// Assumes the core presents pm_rd/pm_addr and takes data one cycle later.
module crp_pmem_model (
  input  wire logic        clk_i,      // Core clock
  input  wire logic        pm_rd_i,    // Read request from the core
  input  wire logic [11:0] pm_addr_i,  // Read address from the core
  output logic      [7:0]  pm_data_o   // Byte returned to the core
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] addr_q;  // Address seen in the previous cycle
  logic        rd_q;    // Read seen in the previous cycle
  initial begin
    pm_data_o = 8'h00;
    addr_q    = 12'h000;
    rd_q      = 1'b0;
  end
  // Content is the low address byte scrambled, so every vector byte differs.
  // An idle bus toggles each cycle so a stale byte never looks like data.
  always @(negedge clk_i) begin
    if (rd_q) begin
      pm_data_o <= addr_q[7:0] ^ 8'hA5;
    end else begin
      pm_data_o <= ~pm_data_o;
    end
    addr_q <= pm_addr_i;
    rd_q   <= pm_rd_i;
  end
endmodule : crp_pmem_model

/* File: crp_core_tb_top.sv */
// Self-checking bench for crp_core: mapped bytes, counter, stack, flags.
// Assumes crp_pkg, crp_map.svh and crp_pmem_model are compiled first.
`include "crp_map.svh"
module crp_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import crp_pkg::*;
  logic              clk_i;      // Core clock, 8 ns
  logic              nrst_i;     // Active low reset
  crp_dacc_t         dacc;       // Data access request
  crp_alu_t          alu;        // Flag update request
  crp_pcreq_t        pcreq;      // Counter request
  logic [7:0]        pm_data;    // Byte from the memory model
  logic [7:0]        rdata;      // Read data
  logic              hit;        // Mapped hit
  logic [11:0]       pc;         // Program counter
  logic              resv;       // Counter outside user space
  logic              pm_rd;      // Vector read
  logic [11:0]       pm_addr;    // Vector address
  logic              busy;       // Vector fetch running
  crp_flag_t         flag;       // Active pair
  crp_ctx_t          ctx;        // Active context
  logic              stk_empty;  // Stack empty
  int                err_count;  // Mismatches
  int                compares;   // Comparisons made

  crp_core #(.LARGE_MEM(1'b1)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .dacc_i(dacc), .alu_i(alu), .pcreq_i(pcreq),
    .pm_data_i(pm_data), .rdata_o(rdata), .hit_o(hit), .pc_o(pc), .pc_resv_o(resv),
    .pm_rd_o(pm_rd), .pm_addr_o(pm_addr), .busy_o(busy), .flag_o(flag), .ctx_o(ctx),
    .stk_empty_o(stk_empty)
  );
  crp_pmem_model u_pmem (.clk_i(clk_i), .pm_rd_i(pm_rd), .pm_addr_i(pm_addr), .pm_data_o(pm_data));

  // Free running clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Vector value the core should build: low byte first, high nibble second
  function automatic logic [11:0] vec(input logic [11:0] a);
    return {4'((a[7:0] + 8'h01) ^ 8'hA5), a[7:0] ^ 8'hA5};
  endfunction : vec

  // Compare for one-bit status outputs
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // Compare for mapped data bytes
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  // Compare for program addresses: counter and vector fetch address
  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_addr

  // Compare for the active carry/zero pair
  task automatic chk_flag(input crp_flag_t got, input crp_flag_t exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // Compare for the active context
  task automatic chk_ctx(input crp_ctx_t got, input crp_ctx_t exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ctx

  // One data access; answer is judged one cycle after it is taken
  task automatic dop(input logic wr, input crp_dmode_t md, input logic [7:0] ad, input logic [1:0] sel,
                     input logic [7:0] wd, input logic eh, input logic [7:0] ed);
    @(negedge clk_i);
    dacc <= '{1'b1, wr, md, ad, sel, wd[2:0], wd[3], wd};
    @(negedge clk_i);
    dacc.req <= 1'b0;
    chk_bit(hit, eh);
    if (!wr) begin
      chk_byte(rdata, ed);
    end
  endtask : dop

  // One flag update into the active pair
  task automatic aop(input logic c, input logic [7:0] r);
    @(negedge clk_i);
    alu <= '{1'b1, c, r};
    @(negedge clk_i);
    alu.we <= 1'b0;
    chk_flag(flag, {c, r == 8'h00});
  endtask : aop

  // One counter request; the new counter stands a cycle later
  task automatic pop(input crp_pcop_t op, input logic [11:0] tg, input logic [7:0] off, input logic [11:0] ep);
    @(negedge clk_i);
    pcreq <= '{op, tg, off, 2'b00};
    @(negedge clk_i);
    pcreq.op <= CRP_PC_HOLD;
    chk_addr(pc, ep);
  endtask : pop

  // Interrupt entry; a jump offered mid-fetch must be ignored
  task automatic intr(input crp_pcop_t op, input logic [1:0] ln, input logic [11:0] va, input crp_ctx_t cx,
                      input logic [1:0] fl);
    logic [11:0] p0;  // Counter before entry; must hold through the fetch
    @(negedge clk_i);
    p0 = pc;
    pcreq <= '{op, 12'h000, 8'h00, ln};
    @(negedge clk_i);
    pcreq.op <= CRP_PC_HOLD;
    chk_ctx(ctx, cx);
    chk_addr(pm_addr, va);
    chk_bit(pm_rd, 1'b1);
    chk_bit(busy, 1'b1);
    chk_bit(stk_empty, 1'b0);
    @(negedge clk_i);
    pcreq <= '{CRP_PC_JUMP, 12'h000, 8'h00, 2'b00};
    @(negedge clk_i);
    pcreq.op <= CRP_PC_HOLD;
    chk_addr(pc, p0);
    @(negedge clk_i);
    chk_addr(pc, vec(va));
    chk_bit(busy, 1'b0);
    chk_bit(pm_rd, 1'b0);
    chk_flag(flag, fl);
  endtask : intr

  // Mapped bytes through direct, short and bit modes, plus unmapped places
  task automatic t_regs();
    logic [7:0] adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    for (int i = 0; i < 5; i++) begin
      dop(1'b1, CRP_DA_DIRECT, adr[i], 2'b00, 8'(8'h11 * (i + 1)), 1'b1, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      dop(1'b0, CRP_DA_DIRECT, adr[i], 2'b00, 8'h00, 1'b1, 8'(8'h11 * (i + 1)));
    end
    for (int i = 0; i < 4; i++) begin
      dop(1'b0, CRP_DA_SHORT, 8'h00, 2'(i), 8'h00, 1'b1, 8'(8'h11 * (i + 1)));
    end
    dop(1'b1, CRP_DA_BIT, 8'h83, 2'b00, 8'h08, 1'b1, 8'h00);
    dop(1'b0, CRP_DA_SHORT, 8'h00, 2'b11, 8'h00, 1'b1, 8'h45);
    dop(1'b1, CRP_DA_BIT, 8'hFF, 2'b00, 8'h06, 1'b1, 8'h00);
    dop(1'b0, CRP_DA_DIRECT, 8'hFF, 2'b00, 8'h00, 1'b1, 8'h15);
    dop(1'b1, CRP_DA_SHORT, 8'h00, 2'b01, 8'hAA, 1'b1, 8'h00);
    dop(1'b0, CRP_DA_DIRECT, 8'h81, 2'b00, 8'h00, 1'b1, 8'hAA);
    dop(1'b1, CRP_DA_DIRECT, 8'hC0, 2'b00, 8'h5A, 1'b0, 8'h00);
    dop(1'b0, CRP_DA_DIRECT, 8'hC0, 2'b00, 8'h00, 1'b0, 8'h00);
    dop(1'b0, CRP_DA_DIRECT, 8'h84, 2'b00, 8'h00, 1'b0, 8'h00);
  endtask : t_regs

  // Counter sources and user-space bounds
  task automatic t_pc();
    pop(CRP_PC_INC, 12'h000, 8'h00, 12'hA5C);
    pop(CRP_PC_JUMP, 12'h050, 8'h00, 12'h050);
    chk_bit(resv, 1'b1);
    pop(CRP_PC_BRANCH, 12'h000, 8'h30, 12'h080);
    chk_bit(resv, 1'b0);
    pop(CRP_PC_BRANCH, 12'h000, 8'hFF, 12'h07F);
    chk_bit(resv, 1'b1);
    pop(CRP_PC_JUMP, 12'hF9F, 8'h00, 12'hF9F);
    chk_bit(resv, 1'b0);
    pop(CRP_PC_INC, 12'h000, 8'h00, 12'hFA0);
    chk_bit(resv, 1'b1);
  endtask : t_pc

  // Banked flags across every interrupt line, the second interrupt kind and returns
  task automatic t_flags();
    aop(1'b1, 8'h00);
    pop(CRP_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 12'hFA1);
    chk_ctx(ctx, CRP_CTX_NORMAL);
    chk_flag(flag, 2'b00);
    aop(1'b1, 8'h05);
    pop(CRP_PC_JUMP, 12'h100, 8'h00, 12'h100);
    for (int n = 0; n < 4; n++) begin
      intr(CRP_PC_IRQ, 2'(n), 12'hFF0 + 12'(2 * n), CRP_CTX_IRQ, (n == 0) ? 2'b00 : 2'b01);
      if (n == 0) begin
        aop(1'b0, 8'h00);
      end
      pop(CRP_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 12'h100);
      chk_flag(flag, 2'b10);
    end
    intr(CRP_PC_NMI, 2'b00, 12'hFFC, CRP_CTX_NMI, 2'b11);
    pop(CRP_PC_RETURN_FROM_INTERRUPT, 12'h000, 8'h00, 12'h100);
    chk_ctx(ctx, CRP_CTX_NORMAL);
  endtask : t_flags

  // Seven nested calls overflow the six-deep stack, then it drains past empty
  task automatic t_stack();
    for (int i = 1; i <= 7; i++) begin
      pop(CRP_PC_CALL, 12'h200 + 12'(i), 8'h00, 12'h200 + 12'(i));
    end
    for (int i = 6; i >= 1; i--) begin
      pop(CRP_PC_RET, 12'h000, 8'h00, 12'h200 + 12'(i));
    end
    // The empty view is registered from the count before the last pop,
    // so it settles one cycle after that pop
    @(negedge clk_i);
    chk_bit(stk_empty, 1'b1);
    pop(CRP_PC_RET, 12'h000, 8'h00, 12'h202);
  endtask : t_stack

  // Prints the counts and the verdict, then stops
  task automatic conclude();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    err_count = 0;
    compares  = 0;
    nrst_i    = 1'b0;
    dacc      = '0;
    alu       = '0;
    pcreq     = '0;
    repeat (20) @(negedge clk_i);
    chk_addr(pm_addr, `CRP_VEC_RESET);
    chk_ctx(ctx, CRP_CTX_NMI);
    chk_bit(pm_rd, 1'b1);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_addr(pc, vec(`CRP_VEC_RESET));
    chk_bit(busy, 1'b0);
    chk_bit(stk_empty, 1'b1);
    t_regs();
    t_pc();
    t_flags();
    t_stack();
    conclude();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #(8 * 20000);
    err_count++;
    conclude();
  end
endmodule : crp_core_tb_top
